// [src/umr_top.v]
// Functional notes
// - Reset or pointer command selects mode one.
// - Mode one access moves pointer to two.
// - Receiver flow negates RTS on full start.
// - Receiver flow reasserts RTS when space frees.
// - Both flow controls set disables automatic RTS.
// - Bit six picks ready or full request.
// - Character mode shows head character error status.
// - Block mode ORs errors until error reset.
// - Parity mode field enables parity generate, check.
// - Parity type selects parity or address mark.
// - Encodings: with, forced, none, multidrop parity.
// - Forced parity sends type bit as constant.
// - Mode two accesses leave pointer unchanged.
`include "umr_regs.vh"

module umr_top (
	input  wire        mclk,
	input  wire        resetn,
	// AHB-Lite slave port.
	input  wire        hsel,
	input  wire [7:0]  haddr,
	input  wire [1:0]  htrans,
	input  wire        hwrite,
	input  wire [2:0]  hsize,
	input  wire [31:0] hwdata,
	input  wire        hready,
	output reg  [31:0] hrdata,
	output reg         hreadyout,
	output reg         hresp,
	// Receiver and FIFO side of the channel.
	input  wire        rx_start_valid,
	input  wire        rx_fifo_full,
	input  wire        receiver_ready,
	input  wire        head_advance,
	input  wire        head_break,
	input  wire        head_frame,
	input  wire        head_parity,
	input  wire        rx_check,
	input  wire [7:0]  rx_data,
	input  wire        rx_par_bit,
	// Transmitter side of the channel.
	input  wire [7:0]  tx_data,
	input  wire        tx_busy,
	// Modem pins.
	input  wire        clear_to_send_in_n,
	output reg         request_to_send_out_n,
	// Outputs to the channel and system.
	output reg         rx_request,
	output reg         tx_parity_en,
	output reg         tx_parity_bit,
	output reg         rx_parity_bad,
	output reg         rx_addr_flag,
	output reg         irq
);

	// ----------------------------------------
	// Parity helper.
	// ----------------------------------------
	// Value of the ninth bit for a character under the given mode.
	function par_bit;
		input [1:0] pm;
		input       pt;
		input [7:0] data;
		begin
			case (pm)
				`UMR_PM_WITH:      par_bit = (^data) ^ pt;
				`UMR_PM_FORCE:     par_bit = pt;
				`UMR_PM_MULTIDROP: par_bit = pt;
				default:           par_bit = 1'b0;
			endcase
		end
	endfunction

	// ----------------------------------------
	// State.
	// ----------------------------------------
	reg  [7:0]  mode1_r;
	reg  [7:0]  mode2_r;
	reg         ptr_second_r;
	reg         rd_pend_r;
	reg  [7:0]  rd_addr_r;
	reg         rd_ptr_r;
	reg         wr_pend_r;
	reg  [7:0]  wr_addr_r;
	reg         wr_ptr_r;
	reg  [2:0]  err_r;
	reg         rts_on_r;
	reg         manual_rts_r;
	reg  [`UMR_INT_WIDTH-1:0] int_stat_r;
	reg  [`UMR_INT_WIDTH-1:0] int_mask_r;
	reg  [`UMR_INT_WIDTH-1:0] int_stat_nxt;
	reg  [2:0]  err_nxt;
	reg         rts_on_nxt;
	reg  [31:0] rdata_nxt;

	wire        cts_level;
	wire        cts_change;
	wire        accept;
	wire        wr_mode;
	wire        wr_cmd;
	wire [2:0]  misc;
	wire        rst_ptr;
	wire        rst_err;
	wire        ptr_now;
	wire        rx_flow;
	wire        tx_flow;
	wire [1:0]  pm;
	wire        pt;
	wire [2:0]  head_err;
	wire        req_src;

	// ----------------------------------------
	// Pin synchroniser.
	// ----------------------------------------
	// Clear-to-send is asynchronous to mclk, so it is filtered first.
	umr_sync #(
		.RESET_VAL (1'b1)
	) u_cts_sync (
		.mclk     (mclk),
		.resetn   (resetn),
		.pin_in   (clear_to_send_in_n),
		.level_r  (cts_level),
		.change_r (cts_change)
	);

	// ----------------------------------------
	// Bus decode.
	// ----------------------------------------
	// A transfer is taken when selected, non-idle and the bus is ready.
	assign accept  = hsel & htrans[1] & hready;
	assign wr_mode = wr_pend_r & (wr_addr_r == `UMR_OFF_MODE);
	assign wr_cmd  = wr_pend_r & (wr_addr_r == `UMR_OFF_COMMAND);
	assign misc    = hwdata[`UMR_CMD_MISC_HI:`UMR_CMD_MISC_LO];
	assign rst_ptr = wr_cmd & (misc == `UMR_MISC_RST_PTR);
	assign rst_err = wr_cmd & (misc == `UMR_MISC_RST_ERR);
	// A pointer reset in this data phase already counts for an overlapping
	// address phase, so a pipelined mode access after it reaches mode one.
	assign ptr_now = ptr_second_r & ~rst_ptr;

	// Mode fields used across the block.
	assign rx_flow  = mode1_r[`UMR_M1_RX_FLOW];
	assign tx_flow  = mode2_r[`UMR_M2_TX_FLOW];
	assign pm       = mode1_r[`UMR_M1_PM_HI:`UMR_M1_PM_LO];
	assign pt       = mode1_r[`UMR_M1_PT];
	assign head_err = {head_break, head_frame, head_parity};
	assign req_src  = mode1_r[`UMR_M1_RX_REQ_SEL] ? rx_fifo_full : receiver_ready;

	// ----------------------------------------
	// Address and data phase tracking.
	// ----------------------------------------
	// Reads take one wait state so that a write in the preceding data
	// phase is committed before the read data is sampled.
	always @(posedge mclk or negedge resetn) begin
		if (!resetn) begin
			rd_pend_r <= 1'b0;
			rd_addr_r <= 8'h00;
			rd_ptr_r  <= 1'b0;
			wr_pend_r <= 1'b0;
			wr_addr_r <= 8'h00;
			wr_ptr_r  <= 1'b0;
			hreadyout <= 1'b1;
			hresp     <= 1'b0;
			hrdata    <= 32'h00000000;
		end else begin
			wr_pend_r <= accept & hwrite;
			rd_pend_r <= accept & ~hwrite;
			if (accept) begin
				wr_addr_r <= haddr;
				rd_addr_r <= haddr;
				wr_ptr_r  <= ptr_now;
				rd_ptr_r  <= ptr_now;
			end
			if (accept && !hwrite) begin
				hreadyout <= 1'b0;
			end else begin
				hreadyout <= 1'b1;
			end
			if (rd_pend_r) begin
				hrdata <= rdata_nxt;
			end
		end
	end

	// ----------------------------------------
	// Mode pointer and mode registers.
	// ----------------------------------------
	// The pointer moves on the address phase so back-to-back accesses
	// each see the register that the previous one left selected.
	always @(posedge mclk or negedge resetn) begin
		if (!resetn) begin
			ptr_second_r <= 1'b0;
			mode1_r      <= `UMR_MODE1_RESET;
			mode2_r      <= `UMR_MODE2_RESET;
		end else begin
			if (accept && (haddr == `UMR_OFF_MODE) && !ptr_now) begin
				ptr_second_r <= 1'b1;
			end else if (rst_ptr) begin
				ptr_second_r <= 1'b0;
			end
			// An access to mode two leaves the pointer where it is.
			if (wr_mode && !wr_ptr_r) begin
				mode1_r <= hwdata[7:0];
			end
			if (wr_mode && wr_ptr_r) begin
				mode2_r <= hwdata[7:0];
			end
		end
	end

	// ----------------------------------------
	// Error status at the FIFO head.
	// ----------------------------------------
	// Block mode keeps a running OR; a new head character landing in the
	// same cycle as the reset command survives it.
	always @* begin
		if (mode1_r[`UMR_M1_ERR_MODE]) begin
			err_nxt = (rst_err ? 3'h0 : err_r)
				| (head_advance ? head_err : 3'h0);
		end else begin
			err_nxt = head_err;
		end
	end

	always @(posedge mclk or negedge resetn) begin
		if (!resetn) begin
			err_r <= 3'h0;
		end else begin
			err_r <= err_nxt;
		end
	end

	// ----------------------------------------
	// Request-to-send control.
	// ----------------------------------------
	// Automatic control works only when exactly one direction owns the
	// pin; with both enabled the pin falls back to the manual level.
	always @* begin
		rts_on_nxt = rts_on_r;
		if (rx_flow && tx_flow) begin
			rts_on_nxt = manual_rts_r;
		end else if (rx_flow) begin
			if (rx_start_valid && rx_fifo_full) begin
				rts_on_nxt = 1'b0;
			end else if (!rx_fifo_full) begin
				rts_on_nxt = 1'b1;
			end
		end else if (tx_flow) begin
			rts_on_nxt = tx_busy;
		end else begin
			rts_on_nxt = manual_rts_r;
		end
	end

	always @(posedge mclk or negedge resetn) begin
		if (!resetn) begin
			manual_rts_r          <= 1'b1;
			rts_on_r              <= 1'b1;
			request_to_send_out_n <= 1'b0;
		end else begin
			if (wr_cmd && (misc == `UMR_MISC_RTS_ON)) begin
				manual_rts_r <= 1'b1;
			end else if (wr_cmd && (misc == `UMR_MISC_RTS_OFF)) begin
				manual_rts_r <= 1'b0;
			end
			rts_on_r              <= rts_on_nxt;
			request_to_send_out_n <= ~rts_on_nxt;
		end
	end

	// ----------------------------------------
	// Parity generation and check.
	// ----------------------------------------
	// Multidrop reuses the ninth bit as the address mark, so parity is
	// only checked in the two parity-bearing modes.
	always @(posedge mclk or negedge resetn) begin
		if (!resetn) begin
			tx_parity_en  <= 1'b1;
			tx_parity_bit <= 1'b0;
			rx_parity_bad <= 1'b0;
			rx_addr_flag  <= 1'b0;
			rx_request    <= 1'b0;
		end else begin
			tx_parity_en  <= (pm != `UMR_PM_NONE);
			tx_parity_bit <= par_bit(pm, pt, tx_data);
			if (rx_check) begin
				rx_parity_bad <= ~pm[1] & (rx_par_bit != par_bit(pm, pt, rx_data));
				rx_addr_flag  <= (pm == `UMR_PM_MULTIDROP) & rx_par_bit;
			end
			rx_request <= req_src;
		end
	end

	// ----------------------------------------
	// Interrupt status and mask.
	// ----------------------------------------
	// Sticky bits clear on a written one; an event in the same cycle wins.
	always @* begin
		int_stat_nxt = int_stat_r;
		if (wr_pend_r && (wr_addr_r == `UMR_OFF_INT_STATUS)) begin
			int_stat_nxt = int_stat_r & ~hwdata[`UMR_INT_WIDTH-1:0];
		end
		int_stat_nxt[`UMR_INT_RX_REQ]   = int_stat_nxt[`UMR_INT_RX_REQ] | req_src;
		int_stat_nxt[`UMR_INT_CTS_CHG]  = int_stat_nxt[`UMR_INT_CTS_CHG] | cts_change;
		int_stat_nxt[`UMR_INT_HEAD_ERR] = int_stat_nxt[`UMR_INT_HEAD_ERR]
			| (head_advance & (|head_err));
	end

	always @(posedge mclk or negedge resetn) begin
		if (!resetn) begin
			int_stat_r <= {`UMR_INT_WIDTH{1'b0}};
			int_mask_r <= {`UMR_INT_WIDTH{1'b0}};
			irq        <= 1'b0;
		end else begin
			int_stat_r <= int_stat_nxt;
			if (wr_pend_r && (wr_addr_r == `UMR_OFF_INT_MASK)) begin
				int_mask_r <= hwdata[`UMR_INT_WIDTH-1:0];
			end
			irq <= |(int_stat_nxt & int_mask_r);
		end
	end

	// ----------------------------------------
	// Read data multiplexer.
	// ----------------------------------------
	// Unmapped and write-only offsets read as zero with an OKAY answer.
	always @* begin
		rdata_nxt = 32'h00000000;
		case (rd_addr_r)
			`UMR_OFF_MODE: begin
				rdata_nxt[7:0] = rd_ptr_r ? mode2_r : mode1_r;
			end
			`UMR_OFF_STATUS: begin
				rdata_nxt[`UMR_ST_BREAK]      = err_r[2];
				rdata_nxt[`UMR_ST_FRAME]      = err_r[1];
				rdata_nxt[`UMR_ST_PARITY]     = err_r[0];
				rdata_nxt[`UMR_ST_ADDR_FLAG]  = rx_addr_flag;
				rdata_nxt[`UMR_ST_PTR_SECOND] = ptr_second_r;
				rdata_nxt[`UMR_ST_CTS]        = ~cts_level;
				rdata_nxt[`UMR_ST_FULL]       = rx_fifo_full;
				rdata_nxt[`UMR_ST_READY]      = receiver_ready;
			end
			`UMR_OFF_INT_STATUS: begin
				rdata_nxt[`UMR_INT_WIDTH-1:0] = int_stat_r;
			end
			`UMR_OFF_INT_MASK: begin
				rdata_nxt[`UMR_INT_WIDTH-1:0] = int_mask_r;
			end
			default: begin
				rdata_nxt = 32'h00000000;
			end
		endcase
	end

endmodule // umr_top

// [common/umr_regs.vh]
`ifndef UMR_REGS_VH
`define UMR_REGS_VH

// ----------------------------------------
// Register byte offsets (word aligned).
// ----------------------------------------
`define UMR_OFF_MODE        8'h00
`define UMR_OFF_COMMAND     8'h04
`define UMR_OFF_STATUS      8'h08
`define UMR_OFF_INT_STATUS  8'h0c
`define UMR_OFF_INT_MASK    8'h10

// ----------------------------------------
// First mode register fields.
// ----------------------------------------
`define UMR_M1_RX_FLOW      7
`define UMR_M1_RX_REQ_SEL   6
`define UMR_M1_ERR_MODE     5
`define UMR_M1_PM_HI        4
`define UMR_M1_PM_LO        3
`define UMR_M1_PT           2
`define UMR_MODE1_RESET     8'h00
`define UMR_MODE2_RESET     8'h00

// ----------------------------------------
// Second mode register field used here.
// ----------------------------------------
`define UMR_M2_TX_FLOW      5

// ----------------------------------------
// Parity mode encodings.
// ----------------------------------------
`define UMR_PM_WITH         2'h0
`define UMR_PM_FORCE        2'h1
`define UMR_PM_NONE         2'h2
`define UMR_PM_MULTIDROP    2'h3

// ----------------------------------------
// Command register miscellaneous field.
// ----------------------------------------
`define UMR_CMD_MISC_HI     6
`define UMR_CMD_MISC_LO     4
`define UMR_MISC_NOP        3'h0
`define UMR_MISC_RST_PTR    3'h1
`define UMR_MISC_RST_ERR    3'h4
`define UMR_MISC_RTS_ON     3'h6
`define UMR_MISC_RTS_OFF    3'h7

// ----------------------------------------
// Status register fields.
// ----------------------------------------
`define UMR_ST_BREAK        7
`define UMR_ST_FRAME        6
`define UMR_ST_PARITY       5
`define UMR_ST_ADDR_FLAG    4
`define UMR_ST_PTR_SECOND   3
`define UMR_ST_CTS          2
`define UMR_ST_FULL         1
`define UMR_ST_READY        0

// ----------------------------------------
// Interrupt status and mask fields.
// ----------------------------------------
`define UMR_INT_RX_REQ      0
`define UMR_INT_CTS_CHG     1
`define UMR_INT_HEAD_ERR    2
`define UMR_INT_WIDTH       3

`endif

// [src/umr_sync.v]
// ----------------------------------------
// Three-stage pin synchroniser.
// ----------------------------------------
// The first stage feeds only the second; a change is accepted once the
// second and third stages agree, which filters a single-stage glitch.
module umr_sync #(
	parameter RESET_VAL = 1'b1
) (
	input  wire mclk,
	input  wire resetn,
	input  wire pin_in,
	output reg  level_r,
	output reg  change_r
);

	reg meta_r;
	reg stage2_r;
	reg stage3_r;

	// Shift the pin in and accept agreed levels.
	always @(posedge mclk or negedge resetn) begin
		if (!resetn) begin
			meta_r   <= RESET_VAL;
			stage2_r <= RESET_VAL;
			stage3_r <= RESET_VAL;
			level_r  <= RESET_VAL;
			change_r <= 1'b0;
		end else begin
			meta_r   <= pin_in;
			stage2_r <= meta_r;
			stage3_r <= stage2_r;
			change_r <= 1'b0;
			if ((stage2_r == stage3_r) && (stage3_r != level_r)) begin
				level_r  <= stage3_r;
				change_r <= 1'b1;
			end
		end
	end

endmodule // umr_sync

// [tb/umr_top_chk.sv]
module umr_top_chk (
	input wire logic       mclk,
	input wire logic       resetn,
	input wire logic       hsel,
	input wire logic [1:0] htrans,
	input wire logic       hwrite,
	input wire logic       hready,
	input wire logic       hreadyout,
	input wire logic       hresp,
	input wire logic       receiver_ready,
	input wire logic       rx_fifo_full,
	input wire logic       rx_request,
	input wire logic       tx_parity_en,
	input wire logic       tx_parity_bit,
	input wire logic       rx_check,
	input wire logic       rx_parity_bad,
	input wire logic       rx_addr_flag
);
	timeunit 1ns;
	timeprecision 1ps;
	// --------
	// Checks.
	// --------
	default clocking cb @(posedge mclk); endclocking
	default disable iff (!resetn);
	// A transfer only counts when selected, not idle and with the bus ready.
	wire logic take_w = hsel && htrans[1] && hready;

	read_wait_a: assert property (take_w && !hwrite |=> !hreadyout ##1 hreadyout)
		else $error("read wait state wrong");
	write_nowait_a: assert property (take_w && hwrite |=> hreadyout)
		else $error("write stalled");
	resp_okay_a: assert property (hresp == 1'b0)
		else $error("response not okay");
	req_source_a: assert property (rx_request == $past(receiver_ready) ||
		rx_request == $past(rx_fifo_full)) else $error("request from no source");
	none_bit_a: assert property (!tx_parity_en |-> !tx_parity_bit)
		else $error("parity bit without parity");
	bad_on_check_a: assert property (!$stable(rx_parity_bad) |-> $past(rx_check))
		else $error("parity flag moved without a check");
	flag_on_check_a: assert property (!$stable(rx_addr_flag) |-> $past(rx_check))
		else $error("address flag moved without a check");
	bad_flag_excl_a: assert property (!(rx_parity_bad && rx_addr_flag))
		else $error("parity and address flag together");
endmodule // umr_top_chk

bind umr_top umr_top_chk u_chk (.mclk, .resetn, .hsel, .htrans, .hwrite, .hready,
	.hreadyout, .hresp, .receiver_ready, .rx_fifo_full, .rx_request, .tx_parity_en,
	.tx_parity_bit, .rx_check, .rx_parity_bad, .rx_addr_flag);

// [tb/umr_far.sv]
module umr_far #(
	parameter int DEPTH = 2
) (
	input  wire logic       mclk,
	input  wire logic       push,
	input  wire logic [2:0] err,
	input  wire logic       pop,
	output logic            rx_start_valid,
	output logic            rx_fifo_full,
	output logic            receiver_ready,
	output logic            head_advance,
	output logic [2:0]      head_err
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [2:0] q[$];
	logic       pend = 1'b0;
	logic [2:0] perr = 3'h0;
	logic       tog = 1'b0;
	// -------------------------
	// Remote sender and FIFO.
	// -------------------------
	// The start bit shows a cycle before the character lands, so a start
	// that arrives while full is seen against the old fill level.
	always @(posedge mclk) begin
		rx_start_valid <= push;
		pend <= push;
		perr <= err;
		tog <= ~tog;
		head_advance <= 1'b0;
		if (pop && q.size() > 0) begin
			void'(q.pop_front());
			if (q.size() > 0)
				head_advance <= 1'b1;
		end
		if (pend && q.size() < DEPTH) begin
			if (q.size() == 0)
				head_advance <= 1'b1;
			q.push_back(perr);
		end
		rx_fifo_full <= q.size() == DEPTH;
		receiver_ready <= q.size() > 0;
		// An empty FIFO has no head; its status lines carry a moving pattern.
		head_err <= (q.size() > 0) ? q[0] : {3{tog}};
	end
	initial begin
		rx_start_valid = 1'b0;
		rx_fifo_full = 1'b0;
		receiver_ready = 1'b0;
		head_advance = 1'b0;
		head_err = 3'h0;
	end
endmodule // umr_far

// [tb/uart_mode_register_one_bench.sv]
module uart_mode_register_one_bench;
	timeunit 1ns;
	timeprecision 1ps;
	logic        mclk, resetn, hsel, hwrite, hreadyout, hresp, push, pop;
	logic [7:0]  haddr, tx_data, rx_data;
	logic [1:0]  htrans;
	logic [31:0] hwdata, hrdata, r, d;
	logic [2:0]  head_err, err;
	logic        rx_start_valid, rx_fifo_full, receiver_ready, head_advance, rx_check;
	logic        rx_par_bit, tx_busy, clear_to_send_in_n, request_to_send_out_n, irq;
	logic        rx_request, tx_parity_en, tx_parity_bit, rx_parity_bad, rx_addr_flag;
	logic [31:0] seed = 32'h0001177d;
	int          err_count = 0;
	int          num_checks = 0;

	umr_top u_dut (.mclk, .resetn, .hsel, .haddr, .htrans, .hwrite, .hsize(3'h2),
		.hwdata, .hready(hreadyout), .hrdata, .hreadyout, .hresp, .rx_start_valid,
		.rx_fifo_full, .receiver_ready, .head_advance, .head_break(head_err[2]),
		.head_frame(head_err[1]), .head_parity(head_err[0]), .rx_check, .rx_data,
		.rx_par_bit, .tx_data, .tx_busy, .clear_to_send_in_n, .request_to_send_out_n,
		.rx_request, .tx_parity_en, .tx_parity_bit, .rx_parity_bad, .rx_addr_flag, .irq);
	umr_far u_far (.mclk, .push, .err, .pop, .rx_start_valid, .rx_fifo_full,
		.receiver_ready, .head_advance, .head_err);

	// ------------------
	// Helpers and bus.
	// ------------------
	function automatic logic [31:0] rnd();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction
	// Ninth bit: computed even or odd parity, zero when off, else the type bit.
	function automatic logic par(input logic [1:0] pm, input logic pt, input logic [7:0] v);
		return (pm == 2'h0) ? (^v ^ pt) : (pm == 2'h2) ? 1'b0 : pt;
	endfunction
	task automatic complete_run();
		if (err_count == 0 && num_checks > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask
	task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
		num_checks++;
		if (got !== exp) begin
			err_count++;
			$display("mismatch at %0t: %s", $time, m);
		end
	endtask
	// Ready only moves on rising edges, so its value at the falling edge is
	// exactly what the next rising edge samples.
	task automatic rdy();
		int n;
		n = 0;
		@(negedge mclk);
		while (hreadyout !== 1'b1) begin
			n++;
			if (n > 40) begin
				$display("mismatch at %0t: bus hang", $time);
				err_count++;
				complete_run();
			end
			@(negedge mclk);
		end
		@(posedge mclk);
	endtask
	task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] v);
		@(posedge mclk);
		hsel <= 1'b1;
		htrans <= 2'h2;
		hwrite <= w;
		haddr <= a;
		rdy();
		hsel <= 1'b0;
		htrans <= 2'h0;
		hwdata <= v;
		rdy();
		r = hrdata;
	endtask
	task automatic set_mode(input logic [7:0] a, input logic [7:0] b);
		bus(1'b1, 8'h04, 32'h10);
		bus(1'b1, 8'h00, {24'h0, a});
		bus(1'b1, 8'h00, {24'h0, b});
	endtask
	task automatic fifo(input logic p, input logic [2:0] e);
		@(posedge mclk);
		push <= p;
		pop <= !p;
		err <= e;
		@(posedge mclk);
		push <= 1'b0;
		pop <= 1'b0;
		repeat (5) @(posedge mclk);
		@(negedge mclk);
	endtask

	initial begin
		mclk = 1'b0;
		forever #2 mclk = ~mclk;
	end

	// ------------
	// Scenarios.
	// ------------
	initial begin
		{resetn, hsel, hwrite, push, pop, rx_check, rx_par_bit, tx_busy} = 8'h00;
		{haddr, tx_data, rx_data, htrans, err} = 29'h0;
		hwdata = 32'h0;
		clear_to_send_in_n = 1'b1;
		repeat (3) @(posedge mclk);
		resetn <= 1'b1;
		bus(1'b0, 8'h08, 32'h0);
		chk(r[3], 1'b0, "pointer after reset");
		d = rnd();
		bus(1'b1, 8'h00, {24'h0, d[7:0]});
		bus(1'b0, 8'h08, 32'h0);
		chk(r[3], 1'b1, "pointer advance");
		bus(1'b1, 8'h00, {24'h0, d[15:8]});
		bus(1'b0, 8'h00, 32'h0);
		chk(r, {24'h0, d[15:8]}, "second mode value");
		bus(1'b0, 8'h08, 32'h0);
		chk(r[3], 1'b1, "pointer kept");
		bus(1'b1, 8'h04, 32'h10);
		bus(1'b0, 8'h00, 32'h0);
		chk(r, {24'h0, d[7:0]}, "first mode value");
		bus(1'b0, 8'h08, 32'h0);
		chk(r[3], 1'b1, "read advances pointer");
		bus(1'b0, 8'h20, 32'h0);
		chk(r, 32'h0, "unmapped read");
		// Every parity mode and type, with random characters both ways.
		for (int i = 0; i < 8; i++) begin
			set_mode({3'h0, i[2:0], 2'h0}, 8'h00);
			d = rnd();
			@(posedge mclk);
			{tx_busy, clear_to_send_in_n, rx_par_bit} <= d[18:16];
			{rx_data, tx_data} <= d[15:0];
			rx_check <= 1'b1;
			@(posedge mclk);
			rx_check <= 1'b0;
			repeat (2) @(negedge mclk);
			chk(tx_parity_en, i[2:1] != 2'h2, "parity enable");
			chk(tx_parity_bit, par(i[2:1], i[0], d[7:0]), "tx ninth bit");
			chk(rx_parity_bad, !i[2] && d[16] != par(i[2:1], i[0], d[15:8]), "rx check");
			chk(rx_addr_flag, i[2:1] == 2'h3 && d[16], "address mark");
		end
		for (int s = 0; s < 2; s++) begin
			set_mode({1'b0, s[0], 6'h10}, 8'h00);
			fifo(1'b1, 3'h0);
			chk(rx_request, !s[0], "request one char");
			fifo(1'b1, 3'h0);
			chk(rx_request, 1'b1, "request full");
			fifo(1'b0, 3'h0);
			fifo(1'b0, 3'h0);
		end
		set_mode(8'h80, 8'h00);
		fifo(1'b1, 3'h0);
		fifo(1'b1, 3'h0);
		chk(request_to_send_out_n, 1'b0, "rts while filling");
		fifo(1'b1, 3'h0);
		chk(request_to_send_out_n, 1'b1, "rts on full start");
		fifo(1'b0, 3'h0);
		chk(request_to_send_out_n, 1'b0, "rts on free entry");
		set_mode(8'h80, 8'h20);
		fifo(1'b1, 3'h0);
		fifo(1'b1, 3'h0);
		chk(request_to_send_out_n, 1'b0, "both flow controls");
		bus(1'b1, 8'h04, 32'h70);
		repeat (2) @(negedge mclk);
		chk(request_to_send_out_n, 1'b1, "manual rts negate");
		bus(1'b1, 8'h04, 32'h60);
		repeat (2) @(negedge mclk);
		chk(request_to_send_out_n, 1'b0, "manual rts assert");
		fifo(1'b0, 3'h0);
		fifo(1'b0, 3'h0);
		set_mode(8'h10, 8'h00);
		fifo(1'b1, 3'h1);
		fifo(1'b1, 3'h4);
		bus(1'b0, 8'h08, 32'h0);
		chk(r[7:5], 3'h1, "head status");
		fifo(1'b0, 3'h0);
		bus(1'b0, 8'h08, 32'h0);
		chk(r[7:5], 3'h4, "next head status");
		fifo(1'b0, 3'h0);
		set_mode(8'h30, 8'h00);
		bus(1'b1, 8'h04, 32'h40);
		fifo(1'b1, 3'h2);
		fifo(1'b1, 3'h0);
		fifo(1'b0, 3'h0);
		bus(1'b0, 8'h08, 32'h0);
		chk(r[7:5], 3'h2, "block status");
		bus(1'b1, 8'h04, 32'h40);
		bus(1'b0, 8'h08, 32'h0);
		chk(r[7:5], 3'h0, "block cleared");
		// Park clear-to-send negated, clear its event, then assert it.
		@(posedge mclk);
		clear_to_send_in_n <= 1'b1;
		repeat (8) @(posedge mclk);
		bus(1'b1, 8'h0c, 32'h2);
		clear_to_send_in_n <= 1'b0;
		repeat (8) @(negedge mclk);
		bus(1'b0, 8'h08, 32'h0);
		chk(r[2], 1'b1, "cts asserted");
		bus(1'b0, 8'h0c, 32'h0);
		chk(r[1], 1'b1, "cts change event");
		// One character still waits, so the ready source keeps status bit 0 set.
		bus(1'b1, 8'h10, 32'h1);
		repeat (2) @(negedge mclk);
		chk(irq, 1'b1, "irq raised");
		bus(1'b1, 8'h10, 32'h0);
		repeat (2) @(negedge mclk);
		chk(irq, 1'b0, "irq masked");
		fifo(1'b0, 3'h0);
		bus(1'b1, 8'h10, 32'h1);
		repeat (2) @(negedge mclk);
		chk(irq, 1'b1, "irq sticky");
		bus(1'b1, 8'h0c, 32'h7);
		repeat (2) @(negedge mclk);
		chk(irq, 1'b0, "irq cleared");
		complete_run();
	end
endmodule // uart_mode_register_one_bench
